// file: rtl/pccr_defs.svh
// offsets, field positions, reset values and widths of the primary config/control registers
`ifndef PCCR_DEFS_SVH
`define PCCR_DEFS_SVH

`define PCCR_ADDR_W 6
`define PCCR_DATA_W 16
`define PCCR_OFS_CFG 6'h04
`define PCCR_OFS_CTRL 6'h06

`define PCCR_CFG_RST 16'h0004
`define PCCR_CTRL_RST 16'h0001

`define PCCR_BIT_PAR 0
`define PCCR_BIT_LMI 1
`define PCCR_CFG_RX_PARITY_CHECK_ENABLE 2
`define PCCR_CFG_RES3 3
`define PCCR_CFG_TRIEN 4
`define PCCR_CFG_OSMEN 5
`define PCCR_CTRL_PLAT_LO 2
`define PCCR_CTRL_PLAT_HI 3
`define PCCR_CTRL_GATE_TIMING_CAPTURE_TRIGGER 4
`define PCCR_CTRL_CLEAR_PRIMARY_REQUEST 5
`define PCCR_CTRL_CLEAR_SECONDARY_REQUEST 6

`define PCCR_SYNC_STAGES 3

`endif

// file: rtl/pccr_pkg.sv
// types shared by the primary config/control register block
package pccr_pkg;
   typedef struct packed {
      logic write;
      logic [5:0] addr;
      logic [15:0] data;
   } pccr_rx_msg_t;

   typedef struct packed {
      logic osm_status;
      logic tristate_flag;
      logic shoot_through_active;
   } pccr_ext_status_t;

   typedef enum logic [1:0] {
      PCCR_PLAT_LVL0 = 2'h0,
      PCCR_PLAT_LVL1 = 2'h1,
      PCCR_PLAT_LVL2 = 2'h2,
      PCCR_PLAT_RSVD = 2'h3
   } pccr_plateau_t;
endpackage

// file: rtl/pccr_regs.sv
// primary configuration and run-time control registers with fault output logic
`timescale 1ns/100ps
`include "pccr_defs.svh"
module pccr_regs
   import pccr_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic rx_valid,
   input wire pccr_rx_msg_t rx_msg,
   input wire logic rx_frame_error,
   input wire pccr_ext_status_t ext_status,
   input wire logic fault_b_event,
   input wire logic shoot_through_event,
   output logic resp_valid_q,
   output logic [15:0] resp_data_q,
   output logic fault_output_a_n_q,
   output logic fault_output_b_n_q,
   output logic clear_primary_request_q,
   output logic clear_secondary_request_q,
   output logic gate_timing_capture_trigger_q,
   output pccr_plateau_t turn_on_plateau_level_q,
   output logic shoot_through_err_q,
   output logic last_message_invalid_q
);
   // ==========================================================
   // configuration state
   logic fault_on_osm_enable_q;
   logic fault_on_tristate_enable_q;
   logic cfg_res3_q;
   logic rx_parity_check_enable_q;

   pccr_ext_status_t ext_q;
   logic osm_prev_q;
   logic tri_prev_q;
   logic osm_rise;
   logic tri_rise;
   logic set_fault_a;
   logic parity_bad;
   logic discard;
   logic accept;
   logic wr_cfg;
   logic wr_ctrl;
   logic [15:0] cfg_word;
   logic [15:0] ctrl_word;
   logic [15:0] rd_word;

   pccr_sync #(
      .WIDTH(3)
   ) u_status_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .async_in(ext_status),
      .level_q(ext_q)
   );

   // ==========================================================
   // message decode
   // odd parity over write, address and data
   assign parity_bad = (^{rx_msg.write, rx_msg.addr, rx_msg.data}) == 1'b0;
   assign discard = rx_frame_error || (rx_parity_check_enable_q && parity_bad);
   assign accept = ce && rx_valid && !discard;
   assign wr_cfg = accept && rx_msg.write && (rx_msg.addr == `PCCR_OFS_CFG);
   assign wr_ctrl = accept && rx_msg.write && (rx_msg.addr == `PCCR_OFS_CTRL);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_on_osm_enable_q <= 1'b0;
         fault_on_tristate_enable_q <= 1'b0;
         cfg_res3_q <= 1'b0;
         rx_parity_check_enable_q <= 1'b1;
      end else if (wr_cfg) begin
         fault_on_osm_enable_q <= rx_msg.data[`PCCR_CFG_OSMEN];
         fault_on_tristate_enable_q <= rx_msg.data[`PCCR_CFG_TRIEN];
         // stored as written; host is expected to keep it zero
         cfg_res3_q <= rx_msg.data[`PCCR_CFG_RES3];
         rx_parity_check_enable_q <= rx_msg.data[`PCCR_CFG_RX_PARITY_CHECK_ENABLE];
      end
   end

   // ==========================================================
   // control register
   // request bits set by a 1 write, cleared by hardware next cycle
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         clear_secondary_request_q <= 1'b0;
         clear_primary_request_q <= 1'b0;
         gate_timing_capture_trigger_q <= 1'b0;
      end else if (ce) begin
         // capture trigger self-clears; zero writes do nothing
         clear_secondary_request_q <= wr_ctrl && rx_msg.data[`PCCR_CTRL_CLEAR_SECONDARY_REQUEST];
         clear_primary_request_q <= wr_ctrl && rx_msg.data[`PCCR_CTRL_CLEAR_PRIMARY_REQUEST];
         gate_timing_capture_trigger_q <= wr_ctrl && rx_msg.data[`PCCR_CTRL_GATE_TIMING_CAPTURE_TRIGGER];
      end
   end

   // plateau field passes straight to the gate drive selection
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         turn_on_plateau_level_q <= PCCR_PLAT_LVL0;
      end else if (wr_ctrl) begin
         turn_on_plateau_level_q <=
            pccr_plateau_t'(rx_msg.data[`PCCR_CTRL_PLAT_HI:`PCCR_CTRL_PLAT_LO]);
      end
   end

   // ==========================================================
   // fault outputs
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         osm_prev_q <= 1'b0;
         tri_prev_q <= 1'b0;
      end else if (ce) begin
         osm_prev_q <= ext_q.osm_status;
         tri_prev_q <= ext_q.tristate_flag;
      end
   end

   assign osm_rise = ext_q.osm_status && !osm_prev_q;
   assign tri_rise = ext_q.tristate_flag && !tri_prev_q;
   // osm edge gated by its enable
   // tristate edge gated by its enable
   assign set_fault_a = (osm_rise && fault_on_osm_enable_q) ||
                        (tri_rise && fault_on_tristate_enable_q);

   // new events win over a simultaneous primary clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_output_a_n_q <= 1'b1;
         fault_output_b_n_q <= 1'b1;
      end else if (ce) begin
         // primary clear releases both fault outputs
         if (set_fault_a) begin
            fault_output_a_n_q <= 1'b0;
         end else if (clear_primary_request_q) begin
            fault_output_a_n_q <= 1'b1;
         end
         if (fault_b_event) begin
            fault_output_b_n_q <= 1'b0;
         end else if (clear_primary_request_q) begin
            fault_output_b_n_q <= 1'b1;
         end
      end
   end

   // active shoot-through condition blocks the secondary clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shoot_through_err_q <= 1'b0;
      end else if (ce) begin
         if (shoot_through_event) begin
            shoot_through_err_q <= 1'b1;
         end else if (clear_secondary_request_q && !ext_q.shoot_through_active) begin
            shoot_through_err_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // response word
   always_comb begin
      cfg_word = 16'h0000;
      cfg_word[`PCCR_CFG_OSMEN] = fault_on_osm_enable_q;
      cfg_word[`PCCR_CFG_TRIEN] = fault_on_tristate_enable_q;
      cfg_word[`PCCR_CFG_RES3] = cfg_res3_q;
      cfg_word[`PCCR_CFG_RX_PARITY_CHECK_ENABLE] = rx_parity_check_enable_q;
      ctrl_word = 16'h0000;
      ctrl_word[`PCCR_CTRL_CLEAR_SECONDARY_REQUEST] = clear_secondary_request_q;
      ctrl_word[`PCCR_CTRL_CLEAR_PRIMARY_REQUEST] = clear_primary_request_q;
      ctrl_word[`PCCR_CTRL_GATE_TIMING_CAPTURE_TRIGGER] = gate_timing_capture_trigger_q;
      ctrl_word[`PCCR_CTRL_PLAT_HI:`PCCR_CTRL_PLAT_LO] = turn_on_plateau_level_q;
      unique case (rx_msg.addr)
         `PCCR_OFS_CFG: rd_word = cfg_word;
         `PCCR_OFS_CTRL: rd_word = ctrl_word;
         default: rd_word = 16'h0000;
      endcase
      // flag reports the message before this one
      rd_word[`PCCR_BIT_LMI] = last_message_invalid_q;
      // odd parity over the whole word
      rd_word[`PCCR_BIT_PAR] = ~^rd_word[15:1];
   end

   // response shows the state before this message's write takes effect
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         resp_valid_q <= 1'b0;
         resp_data_q <= 16'h0000;
         last_message_invalid_q <= 1'b0;
      end else if (ce) begin
         resp_valid_q <= rx_valid;
         if (rx_valid) begin
            resp_data_q <= rd_word;
            // remember whether this message was discarded
            last_message_invalid_q <= discard;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_osm_fault_set: assert property (
      ce && osm_rise && fault_on_osm_enable_q |=> !fault_output_a_n_q)
      else $error("osm edge did not assert fault a");
   a_tri_fault_set: assert property (
      ce && tri_rise && fault_on_tristate_enable_q |=> !fault_output_a_n_q)
      else $error("tristate edge did not assert fault a");
   a_fault_a_quiet: assert property (
      ce && fault_output_a_n_q && !set_fault_a |=> fault_output_a_n_q)
      else $error("fault a asserted without enabled event");
   a_parity_discard: assert property (
      ce && rx_valid && rx_parity_check_enable_q && parity_bad
      |=> last_message_invalid_q)
      else $error("bad parity word not discarded");
   a_parity_off_ok: assert property (
      ce && rx_valid && !rx_parity_check_enable_q && !rx_frame_error
      |=> !last_message_invalid_q)
      else $error("word discarded with parity check off");
   a_lmi_report: assert property (
      ce && rx_valid |=> resp_valid_q && resp_data_q[1] == $past(last_message_invalid_q))
      else $error("response flag does not show previous message");
   a_clear_secondary_request_pulse: assert property (
      ce && wr_ctrl && rx_msg.data[6] ##1 ce && !wr_ctrl
      |-> clear_secondary_request_q ##1 !clear_secondary_request_q)
      else $error("secondary clear request not a single pulse");
   a_clear_primary_request_release: assert property (
      ce && clear_primary_request_q && !set_fault_a && !fault_b_event
      |=> fault_output_a_n_q && fault_output_b_n_q)
      else $error("primary clear did not release fault outputs");
   a_gate_timing_capture_trigger_pulse: assert property (
      ce && wr_ctrl && rx_msg.data[4] ##1 ce && !wr_ctrl
      |-> gate_timing_capture_trigger_q ##1 !gate_timing_capture_trigger_q)
      else $error("capture trigger not a single pulse");
   a_plateau_write: assert property (
      wr_ctrl |=> turn_on_plateau_level_q == $past(rx_msg.data[3:2]))
      else $error("plateau level not taken from write");
   a_stp_hold: assert property (
      ce && clear_secondary_request_q && ext_q.shoot_through_active && shoot_through_err_q
      |=> shoot_through_err_q)
      else $error("shoot-through error cleared while active");
   a_resp_parity: assert property (
      resp_valid_q |-> (^resp_data_q) && resp_data_q[15:7] == 9'h000)
      else $error("response parity or reserved bits wrong");

   c_fault_a: cover property (ce && set_fault_a ##1 clear_primary_request_q);
   c_discard: cover property (ce && rx_valid && discard);
   c_stp_kept: cover property (clear_secondary_request_q && ext_q.shoot_through_active);
endmodule

// file: rtl/pccr_sync.sv
// three-stage synchroniser whose output moves only when stages two and three agree
`timescale 1ns/100ps
module pccr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level_q
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // s1 feeds only s2, never any logic
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else if (ce) begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         level_q <= '0;
      end else if (ce) begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               level_q[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

// file: testbench/pccr_host_model.sv
// host model that presents received words to the register block
`timescale 1ns/100ps
`include "pccr_defs.svh"
module pccr_host_model
   import pccr_pkg::*;
(
   input wire logic core_clk,
   output logic rx_valid,
   output pccr_rx_msg_t rx_msg,
   output logic rx_frame_error
);
   initial begin
      rx_valid = 1'b0;
      rx_msg = '0;
      rx_frame_error = 1'b0;
   end
   // ==========
   // send one word; bad flips the parity
   task automatic send(input logic w, input logic [5:0] a, input logic [15:0] d,
         input logic bad, input logic fe);
      pccr_rx_msg_t m;
      @(posedge core_clk);
      #1;
      m = '{write: w, addr: a, data: d};
      if (w && a == `PCCR_OFS_CFG) m.data[3] = 1'b0;
      m.data[0] = ~^{m.write, m.addr, m.data[15:1]} ^ bad;
      rx_msg = m;
      rx_frame_error = fe;
      rx_valid = 1'b1;
      @(posedge core_clk);
      #1;
      rx_valid = 1'b0;
      // stale bus shows inverted data, never the last word
      rx_msg = ~m;
      rx_frame_error = ~fe;
   endtask
endmodule

// file: testbench/primary_config_control_regs_bench.sv
// self-checking bench of the primary config/control registers
`timescale 1ns/100ps
`include "pccr_defs.svh"
module primary_config_control_regs_bench
   import pccr_pkg::*;
;
   logic core_clk, sys_rst, ce, rx_valid, rx_frame_error, fault_b_event, shoot_through_event;
   pccr_rx_msg_t rx_msg;
   pccr_ext_status_t ext_status;
   logic resp_valid_q, fault_output_a_n_q, fault_output_b_n_q, clear_primary_request_q;
   logic clear_secondary_request_q, gate_timing_capture_trigger_q, shoot_through_err_q;
   logic last_message_invalid_q;
   logic [15:0] resp_data_q, exp_cfg;
   pccr_plateau_t turn_on_plateau_level_q;
   logic [15:0] exp_q[$];
   logic [1:0] exp_plat;
   logic [31:0] rnd;
   logic exp_lmi;
   int miscompares, samples_checked, seed, i;

   pccr_host_model host (.core_clk, .rx_valid, .rx_msg, .rx_frame_error);
   pccr_regs uut (.core_clk, .sys_rst, .ce, .rx_valid, .rx_msg, .rx_frame_error, .ext_status,
      .fault_b_event, .shoot_through_event, .resp_valid_q, .resp_data_q, .fault_output_a_n_q,
      .fault_output_b_n_q, .clear_primary_request_q, .clear_secondary_request_q,
      .gate_timing_capture_trigger_q, .turn_on_plateau_level_q, .shoot_through_err_q,
      .last_message_invalid_q);

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // ==========
   // checking
   task automatic finish_test();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check_word(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic check_bit(input string nm, input logic e, input logic g);
      check_word(nm, {15'h0000, e}, {15'h0000, g});
   endtask
   task automatic step();
      @(posedge core_clk);
      #1;
   endtask
   // response expected = contents before the write, lmi of previous word
   task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
         input logic bad, input logic fe);
      logic [15:0] p;
      logic disc;
      p = 16'h0000;
      if (a == `PCCR_OFS_CFG) p = exp_cfg;
      if (a == `PCCR_OFS_CTRL) p = {12'h000, exp_plat, 2'h0};
      p[1] = exp_lmi;
      p[0] = ~^p[15:1];
      exp_q.push_back(p);
      disc = fe | (bad & exp_cfg[2]);
      if (!disc && w && a == `PCCR_OFS_CFG) exp_cfg = {10'h000, d[5:4], 1'b0, d[2], 2'h0};
      if (!disc && w && a == `PCCR_OFS_CTRL) exp_plat = d[3:2];
      exp_lmi = disc;
      host.send(w, a, d, bad, fe);
   endtask
   task automatic req(input logic [15:0] m);
      // returns in the one cycle where the request pulse stands
      xfer(1'b1, `PCCR_OFS_CTRL, {12'h000, exp_plat, 2'h0} | m, 1'b0, 1'b0);
   endtask
   task automatic wait_a_low();
      int n;
      for (n = 0; n < 12; n++) begin
         step();
         if (fault_output_a_n_q === 1'b0) break;
      end
      check_bit("fault_a_n", 1'b0, fault_output_a_n_q);
      if (n == 12) finish_test();
   endtask
   initial begin
      forever begin
         step();
         if (resp_valid_q === 1'b1) begin
            if (exp_q.size() == 0) begin
               check_word("extra resp", 16'hFFFF, resp_data_q);
            end else begin
               check_word("resp_data", exp_q.pop_front(), resp_data_q);
            end
         end
      end
   end
   // ==========
   // main sequence
   initial begin
      seed = 58291;
      sys_rst = 1'b1;
      ce = 1'b1;
      ext_status = '0;
      fault_b_event = 1'b0;
      shoot_through_event = 1'b0;
      exp_cfg = `PCCR_CFG_RST;
      exp_plat = 2'h0;
      exp_lmi = 1'b0;
      miscompares = 0;
      samples_checked = 0;
      repeat (3) step();
      sys_rst = 1'b0;
      xfer(1'b0, `PCCR_OFS_CFG, 16'h0000, 1'b0, 1'b0);
      xfer(1'b0, `PCCR_OFS_CTRL, 16'h0000, 1'b0, 1'b0);
      for (i = 0; i < 10; i++) begin
         rnd = $random(seed);
         xfer(1'b1, i[0] ? `PCCR_OFS_CTRL : `PCCR_OFS_CFG, rnd[15:0] & 16'hFF8F, 1'b0, 1'b0);
         step();
         check_word("plateau", {14'h0000, exp_plat}, {14'h0000, turn_on_plateau_level_q});
      end
      xfer(1'b1, `PCCR_OFS_CFG, 16'h0004, 1'b0, 1'b0);
      xfer(1'b1, `PCCR_OFS_CFG, 16'h0030, 1'b1, 1'b0);
      check_bit("lmi", 1'b1, last_message_invalid_q);
      xfer(1'b1, `PCCR_OFS_CFG, 16'h0030, 1'b0, 1'b1);
      xfer(1'b1, `PCCR_OFS_CFG, 16'h0000, 1'b0, 1'b0);
      xfer(1'b1, `PCCR_OFS_CFG, 16'h0000, 1'b1, 1'b0);
      xfer(1'b0, 6'h0A, 16'h0000, 1'b0, 1'b0);
      ext_status.tristate_flag = 1'b1;
      repeat (8) step();
      check_bit("fault_a_n off", 1'b1, fault_output_a_n_q);
      ext_status.tristate_flag = 1'b0;
      xfer(1'b1, `PCCR_OFS_CFG, 16'h0010, 1'b0, 1'b0);
      repeat (8) step();
      ext_status.tristate_flag = 1'b1;
      wait_a_low();
      fault_b_event = 1'b1;
      step();
      fault_b_event = 1'b0;
      step();
      check_bit("fault_b_n", 1'b0, fault_output_b_n_q);
      req(16'h0020);
      check_bit("clear_primary_request", 1'b1, clear_primary_request_q);
      step();
      check_bit("clear_primary_request end", 1'b0, clear_primary_request_q);
      check_bit("a_n rel", 1'b1, fault_output_a_n_q);
      check_bit("b_n rel", 1'b1, fault_output_b_n_q);
      xfer(1'b1, `PCCR_OFS_CFG, 16'h0020, 1'b0, 1'b0);
      ext_status.osm_status = 1'b1;
      wait_a_low();
      ext_status.shoot_through_active = 1'b1;
      repeat (6) step();
      shoot_through_event = 1'b1;
      step();
      shoot_through_event = 1'b0;
      req(16'h0040);
      check_bit("clear_secondary_request", 1'b1, clear_secondary_request_q);
      step();
      check_bit("stp kept", 1'b1, shoot_through_err_q);
      ext_status.shoot_through_active = 1'b0;
      repeat (6) step();
      req(16'h0040);
      step();
      check_bit("clear_secondary_request end", 1'b0, clear_secondary_request_q);
      check_bit("stp clr", 1'b0, shoot_through_err_q);
      req(16'h0010);
      check_bit("gate_timing_capture_trigger", 1'b1, gate_timing_capture_trigger_q);
      step();
      check_bit("gate_timing_capture_trigger end", 1'b0, gate_timing_capture_trigger_q);
      // frozen clock enable must swallow a fault event
      ce = 1'b0;
      fault_b_event = 1'b1;
      step();
      fault_b_event = 1'b0;
      ce = 1'b1;
      step();
      check_bit("b_n frozen", 1'b1, fault_output_b_n_q);
      xfer(1'b0, `PCCR_OFS_CTRL, 16'h0000, 1'b0, 1'b0);
      repeat (3) step();
      check_word("pending", 16'h0000, 16'(exp_q.size()));
      finish_test();
   end
endmodule
